/* File: rtl/sclkm_pkg.sv */
// Constants, types and register map of the system clock manager with PLL controls
// Functional notes
// RULE1: System clock from exactly one of three sources
// RULE2: Crystal or master clock is source after reset
// RULE3: Board holds the unused crystal/master input low
// RULE4: PLL reference kept within its frequency limits
// RULE5: Dividers keep PLL output within frequency limits
// RULE6: Safety mode falls back to crystal when unlocked
// RULE7: Writing zero to bypass selects the PLL
// RULE8: Blocks get system clock halved, modulator undivided
// RULE9: Global gate plus per-block gate on each clock
// RULE10: Bus clock runs except in hardware power-down
// RULE11: Phase detector compares matching rising edges
// RULE12: Input divider code 0 and 1 divide by one
// RULE13: Loop factor codes only from 5 to 55
// RULE14: Coarse lock within ten percent, refreshed every 32
// RULE15: Loss of lock readable in status register
// RULE16: Divided reference equals reference over input factor
// RULE17: Fractional mode adds fraction and dither term
// RULE18: Dither-disable bit removes the dither term
// RULE19: No loop factors 5 to 7 in fractional mode
// RULE20: Fraction word written before fractional mode enabled
// RULE21: Loss-of-lock flag sits at status bit seven
// RULE22: Power-down bypasses PLL to crystal, then stops clocks
// RULE23: Source switching is glitch-free
package sclkm_pkg;

    // --------------------------------------------------------------
    // Register offsets
    // --------------------------------------------------------------
    localparam logic [7:0] ADDR_CFG0 = 8'hC0;
    localparam logic [7:0] ADDR_FINE_MULTIPLIER_WORD_LO = 8'hC1;
    localparam logic [7:0] ADDR_FINE_MULTIPLIER_WORD_HI = 8'hC2;
    localparam logic [7:0] ADDR_CFG3 = 8'hC3;
    localparam logic [7:0] ADDR_FRONT = 8'hC4;
    localparam logic [7:0] ADDR_STATUS = 8'hC5;
    localparam logic [7:0] ADDR_CONV = 8'hC6;
    localparam logic [7:0] ADDR_GATE = 8'hC7;
    localparam logic [7:0] ADDR_CORE = 8'hC8;
    localparam logic [7:0] ADDR_BYPASS = 8'hC9;

    // --------------------------------------------------------------
    // Field positions
    // --------------------------------------------------------------
    localparam int CFG0_FINE_MULTIPLIER_WORD_EN_BIT = 7;
    localparam int CFG0_DDIS_BIT = 6;
    localparam int FE_SAFETY_BIT = 7;
    localparam int FE_STANDBY_BIT = 5;
    localparam int CONV_ADC_ON_BIT = 1;
    localparam int GATE_MOD_BIT = 4;
    localparam int GATE_SRC_BIT = 3;
    localparam int GATE_PROC_BIT = 2;
    localparam int CORE_ON_BIT = 0;
    localparam int ST_UNLOCK_BIT = 7;
    localparam int ST_LOCK_BIT = 0;

    // --------------------------------------------------------------
    // Values after reset
    // --------------------------------------------------------------
    localparam logic [3:0] RST_IDF = 4'h1;
    localparam logic [5:0] RST_LDF = 6'h08;
    localparam logic [15:0] RST_FINE_MULTIPLIER_WORD = 16'h0000;
    localparam logic [1:0] RST_BYPASS = 2'h1;

    // --------------------------------------------------------------
    // Lock detector timing
    // --------------------------------------------------------------
    localparam int LOCK_WINDOW = 32;
    localparam int LOCK_TOL_PCT = 10;
    localparam logic [7:0] LOCK_MIN = 8'((LOCK_WINDOW * (100 - LOCK_TOL_PCT) + 99) / 100);
    localparam logic [7:0] LOCK_MAX = 8'((LOCK_WINDOW * (100 + LOCK_TOL_PCT)) / 100);

    // --------------------------------------------------------------
    // Types
    // --------------------------------------------------------------
    typedef enum logic [1:0] {
        SRC_PLL = 2'b00,
        SRC_XTAL = 2'b01,
        SRC_BITCLK = 2'b10
    } sclkm_src_e;

    typedef enum logic [1:0] {
        PS_RUN = 2'b00,
        PS_BYPASS = 2'b01,
        PS_OFF = 2'b10
    } sclkm_pwr_e;

    typedef struct packed {
        logic fractional_mode_enable;
        logic dither_disable_bit;
        logic [3:0] input_divide_factor;
        logic [5:0] loop_divider_code;
        logic [15:0] fine_multiplier_bits;
        logic safety;
        logic pll_standby;
        logic adc_on;
        logic mod_on;
        logic src_on;
        logic proc_on;
        logic core_on;
        logic [1:0] bypass;
    } sclkm_cfg_s;

endpackage

/* File: rtl/sclkm_top.sv */
// System clock manager: source select, block clock gating and PLL digital control
`timescale 1ns/10ps
`default_nettype none
module sclkm_top
    import sclkm_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset,
    input wire logic reg_wr_en,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic serial_bit_clock_in,
    input wire logic crystal_clock_in,
    input wire logic pll_reference_input,
    input wire logic controlled_oscillator,
    input wire logic hw_powerdown,
    output logic sys_clk_out,
    output logic [2:0] block_clk,
    output logic mod_clk,
    output logic bus_clk_en,
    output logic pll_standby_out,
    output logic phase_up,
    output logic phase_down,
    output logic coarse_lock_flag,
    output logic [22:0] fine_multiplier_word,
    output logic [1:0] active_source
);

    // Level of the chosen source, as sampled on this edge
    function automatic logic src_level(input logic [1:0] sel, input logic bclk,
                                       input logic xtal, input logic pll);
        case (sel)
            SRC_PLL: src_level = pll;
            SRC_BITCLK: src_level = bclk;
            default: src_level = xtal;
        endcase
    endfunction

    // Codes 0 and 1 both give one; anything else is its own value
    function automatic logic [6:0] div_factor(input logic [5:0] code);
        div_factor = (code < 6'h02) ? 7'h01 : {1'b0, code};
    endfunction

    // --------------------------------------------------------------
    // Register file
    // --------------------------------------------------------------
    sclkm_cfg_s cfg_q, cfg_d;
    logic [7:0] rdata_q, rdata_d;
    logic lock_q, lock_d;

    // Software writes; unmapped offsets are ignored
    always_comb
    begin
        cfg_d = cfg_q;
        if (reg_wr_en)
        begin
            case (reg_addr)
                ADDR_CFG0:
                begin
                    cfg_d.fractional_mode_enable = reg_wdata[CFG0_FINE_MULTIPLIER_WORD_EN_BIT];
                    cfg_d.dither_disable_bit = reg_wdata[CFG0_DDIS_BIT];
                    cfg_d.input_divide_factor = reg_wdata[3:0]; // see RULE12
                end
                ADDR_FINE_MULTIPLIER_WORD_LO: cfg_d.fine_multiplier_bits[7:0] = reg_wdata;
                ADDR_FINE_MULTIPLIER_WORD_HI: cfg_d.fine_multiplier_bits[15:8] = reg_wdata;
                ADDR_CFG3: cfg_d.loop_divider_code = reg_wdata[5:0];
                ADDR_FRONT:
                begin
                    cfg_d.safety = reg_wdata[FE_SAFETY_BIT];
                    cfg_d.pll_standby = reg_wdata[FE_STANDBY_BIT];
                end
                ADDR_CONV: cfg_d.adc_on = reg_wdata[CONV_ADC_ON_BIT];
                ADDR_GATE:
                begin
                    cfg_d.mod_on = reg_wdata[GATE_MOD_BIT];
                    cfg_d.src_on = reg_wdata[GATE_SRC_BIT];
                    cfg_d.proc_on = reg_wdata[GATE_PROC_BIT];
                end
                ADDR_CORE: cfg_d.core_on = reg_wdata[CORE_ON_BIT];
                ADDR_BYPASS: cfg_d.bypass = reg_wdata[1:0]; // see RULE7
                default: cfg_d = cfg_q;
            endcase
        end
    end

    // Read data is registered so it never glitches with the address
    always_comb
    begin
        rdata_d = 8'h00;
        case (reg_addr)
            ADDR_CFG0:
            begin
                rdata_d[CFG0_FINE_MULTIPLIER_WORD_EN_BIT] = cfg_q.fractional_mode_enable;
                rdata_d[CFG0_DDIS_BIT] = cfg_q.dither_disable_bit;
                rdata_d[3:0] = cfg_q.input_divide_factor;
            end
            ADDR_FINE_MULTIPLIER_WORD_LO: rdata_d = cfg_q.fine_multiplier_bits[7:0];
            ADDR_FINE_MULTIPLIER_WORD_HI: rdata_d = cfg_q.fine_multiplier_bits[15:8];
            ADDR_CFG3: rdata_d[5:0] = cfg_q.loop_divider_code;
            ADDR_FRONT:
            begin
                rdata_d[FE_SAFETY_BIT] = cfg_q.safety;
                rdata_d[FE_STANDBY_BIT] = cfg_q.pll_standby;
            end
            ADDR_STATUS:
            begin
                rdata_d[ST_UNLOCK_BIT] = ~lock_q; // see RULE15 RULE21
                rdata_d[ST_LOCK_BIT] = lock_q;
            end
            ADDR_CONV: rdata_d[CONV_ADC_ON_BIT] = cfg_q.adc_on;
            ADDR_GATE:
            begin
                rdata_d[GATE_MOD_BIT] = cfg_q.mod_on;
                rdata_d[GATE_SRC_BIT] = cfg_q.src_on;
                rdata_d[GATE_PROC_BIT] = cfg_q.proc_on;
            end
            ADDR_CORE: rdata_d[CORE_ON_BIT] = cfg_q.core_on;
            ADDR_BYPASS: rdata_d[1:0] = cfg_q.bypass;
            default: rdata_d = 8'h00;
        endcase
    end

    // Register file storage; crystal is the source after reset
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            cfg_q <= '0;
            cfg_q.input_divide_factor <= RST_IDF;
            cfg_q.loop_divider_code <= RST_LDF;
            cfg_q.fine_multiplier_bits <= RST_FINE_MULTIPLIER_WORD;
            cfg_q.bypass <= RST_BYPASS; // see RULE2
            rdata_q <= 8'h00;
        end
        else
        begin
            cfg_q <= cfg_d;
            rdata_q <= rdata_d;
        end
    end

    // --------------------------------------------------------------
    // Power-down sequencer and source selection
    // --------------------------------------------------------------
    sclkm_pwr_e pwr_q, pwr_d;
    logic [1:0] src_q, src_d, want_src;
    logic sys_q, sys_d;
    logic [2:0] div_q, div_d;

    // Wanted source: forced to crystal outside run, or when PLL unusable
    always_comb
    begin
        want_src = SRC_XTAL;
        if (pwr_q == PS_RUN)
        begin
            case (cfg_q.bypass)
                SRC_PLL: want_src = ((cfg_q.safety && !lock_q) || cfg_q.pll_standby)
                                    ? SRC_XTAL : SRC_PLL; // see RULE1 RULE6
                SRC_BITCLK: want_src = SRC_BITCLK;
                default: want_src = SRC_XTAL;
            endcase
        end
    end

    // Switch only while both old and new clocks sit low, so no pulse is cut
    always_comb
    begin
        src_d = src_q;
        if (want_src != src_q && !sys_q &&
            !src_level(want_src, serial_bit_clock_in, crystal_clock_in, controlled_oscillator))
        begin
            src_d = want_src; // see RULE23
        end
        pwr_d = pwr_q;
        case (pwr_q)
            PS_RUN: if (hw_powerdown) pwr_d = PS_BYPASS;
            PS_BYPASS:
            begin
                // Leave only once the halved clocks are back low, else one stays stuck high
                if (src_q == SRC_XTAL && !sys_q && div_q == 3'h0) pwr_d = PS_OFF; // see RULE22
            end
            PS_OFF: if (!hw_powerdown) pwr_d = PS_RUN;
            default: pwr_d = PS_RUN;
        endcase
        sys_d = (pwr_d == PS_OFF) ? 1'b0 :
                src_level(src_d, serial_bit_clock_in, crystal_clock_in, controlled_oscillator);
    end

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            pwr_q <= PS_RUN;
            src_q <= SRC_XTAL;
            sys_q <= 1'b0;
        end
        else
        begin
            pwr_q <= pwr_d;
            src_q <= src_d;
            sys_q <= sys_d;
        end
    end

    // --------------------------------------------------------------
    // Peripheral clock gating and division
    // --------------------------------------------------------------
    logic [3:0] gate_q, gate_d, gate_want;
    logic mod_q, mod_d;
    logic sys_rise;

    assign sys_rise = sys_d && !sys_q;

    // Global core gate ANDed with each block's own gate; moves only while low
    always_comb
    begin
        gate_want[0] = cfg_q.adc_on;
        gate_want[1] = cfg_q.proc_on;
        gate_want[2] = cfg_q.src_on;
        gate_want[3] = cfg_q.mod_on;
        gate_d = gate_q;
        if (!sys_q)
        begin
            gate_d = (cfg_q.core_on && pwr_q == PS_RUN) ? gate_want : 4'h0; // see RULE9
        end
        mod_d = sys_d && gate_d[3]; // see RULE8
    end

    // Halving dividers finish a high half before stopping
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++)
        begin : g_div
            always_comb
            begin
                div_d[gi] = div_q[gi];
                if (sys_rise && (gate_d[gi] || div_q[gi]))
                begin
                    div_d[gi] = ~div_q[gi]; // see RULE8
                end
            end
        end
    endgenerate

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            gate_q <= 4'h0;
            div_q <= 3'h0;
            mod_q <= 1'b0;
        end
        else
        begin
            gate_q <= gate_d;
            div_q <= div_d;
            mod_q <= mod_d;
        end
    end

    // --------------------------------------------------------------
    // PLL dividers, phase detector and lock detector
    // --------------------------------------------------------------
    logic ref_q, vco_q, up_q, up_d, dn_q, dn_d, ref_p, fb_p;
    logic [3:0] idf_cnt_q, idf_cnt_d;
    logic [6:0] ldf_cnt_q, ldf_cnt_d, ldf_mod;
    logic [15:0] acc_q, acc_d;
    logic carry_q, carry_d;
    logic [4:0] win_q, win_d;
    logic [7:0] fb_cnt_q, fb_cnt_d, fb_total;
    logic [22:0] word_q, word_d;
    logic [16:0] acc_sum;

    // Standby clears the dividers and keeps them at zero; the oscillator is off anyway
    always_comb
    begin
        ref_p = 1'b0;
        fb_p = 1'b0;
        idf_cnt_d = idf_cnt_q;
        ldf_cnt_d = ldf_cnt_q;
        acc_d = acc_q;
        carry_d = carry_q;
        acc_sum = {1'b0, acc_q} + {1'b0, cfg_q.fine_multiplier_bits} +
                  {16'h0000, !cfg_q.dither_disable_bit}; // see RULE18
        // Carry adds one extra oscillator cycle, averaging the fraction in
        ldf_mod = div_factor(cfg_q.loop_divider_code) + {6'h00, carry_q}; // see RULE17
        if (cfg_q.pll_standby)
        begin
            idf_cnt_d = 4'h0;
            ldf_cnt_d = 7'h00;
        end
        else
        begin
            if (pll_reference_input && !ref_q)
            begin
                if ({3'h0, idf_cnt_q} >= div_factor({2'h0, cfg_q.input_divide_factor}) - 7'h01)
                begin
                    idf_cnt_d = 4'h0;
                    ref_p = 1'b1; // see RULE16
                end
                else
                begin
                    idf_cnt_d = idf_cnt_q + 4'h1;
                end
            end
            if (controlled_oscillator && !vco_q)
            begin
                if (ldf_cnt_q >= ldf_mod - 7'h01)
                begin
                    ldf_cnt_d = 7'h00;
                    fb_p = 1'b1;
                    acc_d = cfg_q.fractional_mode_enable ? acc_sum[15:0] : 16'h0000;
                    carry_d = cfg_q.fractional_mode_enable && acc_sum[16];
                end
                else
                begin
                    ldf_cnt_d = ldf_cnt_q + 7'h01;
                end
            end
        end
        // Rising edge of each input sets its flag; both set cancels
        up_d = up_q || ref_p; // see RULE11
        dn_d = dn_q || fb_p;
        if (up_d && dn_d)
        begin
            up_d = 1'b0;
            dn_d = 1'b0;
        end
        // Coarse lock: feedback edges per window of divided-reference edges
        fb_total = fb_cnt_q + {7'h00, fb_p};
        fb_cnt_d = (fb_total == 8'hFF) ? fb_cnt_q : fb_total;
        win_d = win_q;
        lock_d = lock_q;
        if (ref_p)
        begin
            win_d = win_q + 5'h01;
            if (win_q == 5'(LOCK_WINDOW - 1))
            begin
                lock_d = (fb_total >= LOCK_MIN) && (fb_total <= LOCK_MAX); // see RULE14
                fb_cnt_d = 8'h00;
            end
        end
        if (cfg_q.pll_standby)
        begin
            lock_d = 1'b0;
        end
        word_d = {cfg_q.loop_divider_code,
                  cfg_q.fractional_mode_enable ? cfg_q.fine_multiplier_bits : 16'h0000,
                  cfg_q.fractional_mode_enable && !cfg_q.dither_disable_bit};
    end

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            ref_q <= 1'b0;
            vco_q <= 1'b0;
            up_q <= 1'b0;
            dn_q <= 1'b0;
            idf_cnt_q <= 4'h0;
            ldf_cnt_q <= 7'h00;
            acc_q <= 16'h0000;
            carry_q <= 1'b0;
            win_q <= 5'h00;
            fb_cnt_q <= 8'h00;
            lock_q <= 1'b0;
            word_q <= 23'h000000;
        end
        else
        begin
            ref_q <= pll_reference_input;
            vco_q <= controlled_oscillator;
            up_q <= up_d;
            dn_q <= dn_d;
            idf_cnt_q <= idf_cnt_d;
            ldf_cnt_q <= ldf_cnt_d;
            acc_q <= acc_d;
            carry_q <= carry_d;
            win_q <= win_d;
            fb_cnt_q <= fb_cnt_d;
            lock_q <= lock_d;
            word_q <= word_d;
        end
    end

    // Outputs
    assign reg_rdata = rdata_q;
    assign sys_clk_out = sys_q;
    assign block_clk = div_q;
    assign mod_clk = mod_q;
    assign bus_clk_en = (pwr_q != PS_OFF); // see RULE10
    assign pll_standby_out = cfg_q.pll_standby;
    assign phase_up = up_q;
    assign phase_down = dn_q;
    assign coarse_lock_flag = lock_q;
    assign fine_multiplier_word = word_q;
    assign active_source = src_q;

    // --------------------------------------------------------------
    // Checks
    // --------------------------------------------------------------
    a_src_legal: assert property (@(posedge core_clk) disable iff (reset) // see RULE1
        src_q != 2'b11) else $error("active source code out of range");
    a_reset_xtal: assert property (@(posedge core_clk) // see RULE2
        $fell(reset) |-> src_q == SRC_XTAL && cfg_q.bypass == RST_BYPASS)
        else $error("source after reset is not crystal");
    a_safety_fall: assert property (@(posedge core_clk) disable iff (reset) // see RULE6
        (cfg_q.safety && !lock_q && cfg_q.bypass == SRC_PLL && src_q == SRC_PLL &&
         !sys_q && !crystal_clock_in)
        |=> src_q == SRC_XTAL) else $error("no fallback on unlock");
    a_switch_low: assert property (@(posedge core_clk) disable iff (reset) // see RULE23
        (src_q != $past(src_q)) |-> !$past(sys_q) && !sys_q)
        else $error("source switched during high phase");
    a_div_half: assert property (@(posedge core_clk) disable iff (reset) // see RULE8
        $rose(div_q[0]) |-> $rose(sys_q)) else $error("divider moved off system edge");
    a_gate_off: assert property (@(posedge core_clk) disable iff (reset) // see RULE9
        (!cfg_q.core_on && !sys_q) |=> gate_q == 4'h0) else $error("global gate ignored");
    a_pd_bus: assert property (@(posedge core_clk) disable iff (reset) // see RULE10 RULE22
        (pwr_q == PS_OFF) |-> !bus_clk_en && src_q == SRC_XTAL && !sys_q && div_q == 3'h0 && !mod_q)
        else $error("power-down state wrong");
    a_pfd_pair: assert property (@(posedge core_clk) disable iff (reset) // see RULE11
        !(up_q && dn_q)) else $error("both phase outputs high");
    a_lock_win: assert property (@(posedge core_clk) disable iff (reset) // see RULE14
        (lock_q != $past(lock_q) && !$past(cfg_q.pll_standby)) |-> $past(win_q) == 5'h1F)
        else $error("lock changed outside window end");
    a_unlock_rd: assert property (@(posedge core_clk) disable iff (reset) // see RULE15 RULE21
        (reg_addr == ADDR_STATUS) |=> reg_rdata[ST_UNLOCK_BIT] == !$past(lock_q))
        else $error("unlock status bit wrong");

endmodule
`default_nettype wire

/* File: testbench/system_clock_manager_pll_tb.sv */
// Self-checking bench for the system clock manager with PLL controls
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin num_errors++; \
    $display("BAD %s exp %0h got %0h", nm, e, g); end end
module system_clock_manager_pll_tb;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic reg_wr_en = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic serial_bit_clock_in = 1'b0;
    logic crystal_clock_in = 1'b0;
    logic pll_reference_input = 1'b0;
    logic controlled_oscillator = 1'b0;
    logic hw_powerdown = 1'b0;
    logic osc_run = 1'b1;
    logic counting = 1'b0;
    logic [7:0] ph = 8'h00;
    logic [7:0] rdv;
    logic [7:0] reg_rdata;
    logic sys_clk_out, mod_clk, bus_clk_en, coarse_lock_flag;
    logic pll_standby_out, phase_up, phase_down;
    logic [2:0] block_clk;
    logic [22:0] fine_multiplier_word;
    logic [1:0] active_source;
    int num_errors = 0;
    int n_checks = 0;
    int cycles = 0;
    int k, cm, cb0, cb1, cb2;
    // Rows of {offset, write value, expected read value}
    logic [23:0] rows [9] = '{24'hC15A5A, 24'hC2A5A5, 24'hC30808, 24'hC00303, 24'hC00101,
        24'h50FF00, 24'hC60202, 24'hC71C1C, 24'hC80101};

    sclkm_top dut (.core_clk(core_clk), .reset(reset), .reg_wr_en(reg_wr_en),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .serial_bit_clock_in(serial_bit_clock_in), .crystal_clock_in(crystal_clock_in),
        .pll_reference_input(pll_reference_input),
        .controlled_oscillator(controlled_oscillator), .hw_powerdown(hw_powerdown),
        .sys_clk_out(sys_clk_out), .block_clk(block_clk), .mod_clk(mod_clk),
        .bus_clk_en(bus_clk_en), .pll_standby_out(pll_standby_out),
        .phase_up(phase_up), .phase_down(phase_down),
        .coarse_lock_flag(coarse_lock_flag), .fine_multiplier_word(fine_multiplier_word),
        .active_source(active_source));

    // ----------------------------------------
    // Clocks and source levels
    // ----------------------------------------
    always #4 core_clk = ~core_clk;
    // Oscillator at 8x reference, so a loop code of 8 gives exact lock
    always @(posedge core_clk)
    begin
        ph <= ph + 8'h01;
        crystal_clock_in <= ph[2];
        serial_bit_clock_in <= ph[3];
        pll_reference_input <= ph[4];
        controlled_oscillator <= osc_run & ph[1];
    end
    // Edge counters run in their own processes to avoid sampling races
    always @(posedge mod_clk) if (counting) cm++;
    always @(posedge block_clk[0]) if (counting) cb0++;
    always @(posedge block_clk[1]) if (counting) cb1++;
    always @(posedge block_clk[2]) if (counting) cb2++;
    // Hang guard, well above the lock waits of the run
    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 60000)
        begin
            num_errors++;
            conclude();
        end
    end

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr_en <= 1'b1;
        @(posedge core_clk);
        reg_wr_en <= 1'b0;
        #1;
    endtask
    task rd(input logic [7:0] a);
        @(posedge core_clk);
        reg_addr <= a;
        repeat (2) @(posedge core_clk);
        #1 rdv = reg_rdata;
    endtask
    task count_rises;
        cm = 0;
        cb0 = 0;
        cb1 = 0;
        cb2 = 0;
        counting = 1'b1;
        repeat (256) @(posedge core_clk);
        #1 counting = 1'b0;
    endtask
    task conclude;
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        repeat (3) @(posedge core_clk);
        reset <= 1'b0;
        for (k = 0; k < 9; k++)
        begin
            wr(rows[k][23:16], rows[k][15:8]);
            rd(rows[k][23:16]);
            `CHK("readback", rows[k][7:0], rdv)
        end
        `CHK("word", {6'h08, 16'h0000}, fine_multiplier_word[22:1])
        $display("register table done");
        // Fraction already written, now fractional mode with and without dither
        wr(8'hC0, 8'h81);
        #16 `CHK("dither on", 1'b1, fine_multiplier_word[0])
        `CHK("fine_multiplier_word word", {6'h08, 16'hA55A}, fine_multiplier_word[22:1])
        wr(8'hC0, 8'hC1);
        #16 `CHK("dither off", 1'b0, fine_multiplier_word[0])
        wr(8'hC0, 8'h01);
        count_rises();
        `CHK("mod runs", 1'b1, cm > 20)
        `CHK("halved", 1'b1, (2 * cb0 >= cm - 2) && (2 * cb0 <= cm + 2))
        `CHK("halved src", 1'b1, (2 * cb2 >= cm - 2) && (2 * cb2 <= cm + 2))
        wr(8'hC7, 8'h0C);
        count_rises();
        `CHK("mod gated", 0, cm)
        `CHK("proc kept", 1'b1, cb1 > 5)
        wr(8'hC7, 8'h1C);
        wr(8'hC8, 8'h00);
        count_rises();
        `CHK("global gate", 0, cm + cb0 + cb1 + cb2)
        wr(8'hC8, 8'h01);
        $display("gating done");
        wr(8'hC9, 8'h02);
        for (k = 0; k < 400 && active_source !== 2'h2; k++) #8;
        `CHK("bit clock src", 2'h2, active_source)
        wr(8'hC9, 8'h00);
        for (k = 0; k < 400 && active_source !== 2'h0; k++) #8;
        `CHK("pll src", 2'h0, active_source)
        for (k = 0; k < 4000 && coarse_lock_flag !== 1'b1; k++) #8;
        `CHK("lock", 1'b1, coarse_lock_flag)
        wr(8'hC4, 8'h80);
        #800 `CHK("locked keeps pll", 2'h0, active_source)
        @(posedge core_clk) osc_run <= 1'b0;
        for (k = 0; k < 4000 && coarse_lock_flag !== 1'b0; k++) #8;
        `CHK("unlock", 1'b0, coarse_lock_flag)
        `CHK("up on stall", 1'b1, phase_up)
        `CHK("down on stall", 1'b0, phase_down)
        for (k = 0; k < 400 && active_source !== 2'h1; k++) #8;
        `CHK("fallback", 2'h1, active_source)
        rd(8'hC5);
        `CHK("unlock bit", 1'b1, rdv[7])
        @(posedge core_clk) osc_run <= 1'b1;
        for (k = 0; k < 5000 && active_source !== 2'h0; k++) #8;
        `CHK("relock pll", 2'h0, active_source)
        $display("source and lock done");
        @(posedge core_clk) hw_powerdown <= 1'b1;
        for (k = 0; k < 400 && bus_clk_en !== 1'b0; k++) #8;
        `CHK("bus clk off", 1'b0, bus_clk_en)
        `CHK("pd source", 2'h1, active_source)
        `CHK("pd clocks", 5'h00, {sys_clk_out, mod_clk, block_clk})
        @(posedge core_clk) hw_powerdown <= 1'b0;
        for (k = 0; k < 100 && bus_clk_en !== 1'b1; k++) #8;
        `CHK("bus clk on", 1'b1, bus_clk_en)
        $display("power-down done");
        wr(8'hC4, 8'hA0);
        for (k = 0; k < 400 && active_source !== 2'h1; k++) #8;
        #16 `CHK("standby out", 1'b1, pll_standby_out)
        `CHK("standby src", 2'h1, active_source)
        `CHK("standby lock", 1'b0, coarse_lock_flag)
        $display("standby done");
        @(posedge core_clk) reset <= 1'b1;
        repeat (3) @(posedge core_clk);
        reset <= 1'b0;
        #1 `CHK("rst source", 2'h1, active_source)
        `CHK("rst lock", 1'b0, coarse_lock_flag)
        `CHK("rst standby", 1'b0, pll_standby_out)
        rd(8'hC9);
        `CHK("rst bypass", 8'h01, rdv)
        `CHK("rst word", {6'h08, 17'h00000}, fine_multiplier_word)
        $display("reset done");
        conclude();
    end
endmodule
`default_nettype wire
